// >>> src/qet_timer_top.sv
// core timer with encoder interface and two auxiliary timers
// assumes pins synchronous-safe after two flops, register port strobes one cycle
`timescale 1ns/100ps
module qet_timer_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  // count and phase pins
  input wire logic coreCountIn,
  input wire logic coreDirIn,
  input wire logic auxACountIn,
  input wire logic auxADirIn,
  input wire logic auxBCountIn,
  input wire logic auxBDirIn,
  // core timer outputs
  output logic timerOutputLine,
  output logic coreIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [5:0] pinIn;
  logic [5:0] pinMeta_reg;
  logic [5:0] pinSync_reg;
  logic [5:0] pinPrev_reg;
  logic [5:0] pinRise;
  logic [5:0] pinFall;
  logic [15:0] ctrl_reg [0:2];
  logic [15:0] ctrl_next [0:2];
  logic [15:0] cnt_reg [0:2];
  logic [15:0] presCnt_reg;
  logic [1:0] baseSel_reg;
  logic [15:0] regRdData_reg;
  logic [15:0] rdMux;
  logic coreIrq_reg;
  logic timerOutputLine_reg;
  logic [2:0] step;
  logic [2:0] down;
  logic [2:0] wrCtrl;
  logic [2:0] wrCnt;
  logic coreOvf;
  logic otlRise;
  logic otlFall;
  logic encMode;
  logic rotMode;
  logic dirFlip;
  logic coreRun;

  assign pinIn = {auxBDirIn, auxBCountIn, auxADirIn, auxACountIn, coreDirIn, coreCountIn};
  assign regRdData = regRdData_reg;
  assign coreIrq = coreIrq_reg;
  assign timerOutputLine = timerOutputLine_reg;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  always_ff @(posedge mclk) begin
    if (rst) begin
      pinMeta_reg <= 6'h00;
      pinSync_reg <= 6'h00;
      pinPrev_reg <= 6'h00;
    end else begin
      pinMeta_reg <= pinIn;
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg;
    end
  end

  // edges only from the stable pair; pulses faster than this are lost by design
  assign pinRise = pinSync_reg & ~pinPrev_reg;
  assign pinFall = ~pinSync_reg & pinPrev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler

  always_ff @(posedge mclk) begin
    if (rst) begin
      presCnt_reg <= qet_pkg::PRES_RST;
    end else begin
      presCnt_reg <= presCnt_reg + qet_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      baseSel_reg <= qet_pkg::BASE_RST;
    end else if (regWr && regAddr == qet_pkg::REG_PRESC) begin
      baseSel_reg <= regWrData[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode

  always_comb begin
    for (int i = 0; i < qet_pkg::NUM_TMR; i++) begin
      wrCtrl[i] = regWr && (regAddr == qet_pkg::ctrlAddr(i));
      wrCnt[i] = regWr && (regAddr == qet_pkg::cntAddr(i));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-timer step decoders

  assign coreRun = ctrl_reg[0][qet_pkg::F_RUN];

  for (genvar i = 0; i < qet_pkg::NUM_TMR; i++) begin : gUnit
    localparam int PC = i * qet_pkg::PIN_PER_TMR + qet_pkg::PIN_CNT_OFS;
    localparam int PD = i * qet_pkg::PIN_PER_TMR + qet_pkg::PIN_DIR_OFS;
    logic [3:0] presShift;
    qet_step_if sif();
    qet_step_decode uDec (
      .sif(sif.decoder)
    );
    assign presShift = qet_pkg::PRES_MIN_SHIFT + {2'h0, baseSel_reg} + {1'h0, ctrl_reg[i][qet_pkg::F_SEL +: 3]};
    assign sif.mode = ctrl_reg[i][qet_pkg::F_MODE +: 3];
    assign sif.sel = ctrl_reg[i][qet_pkg::F_SEL +: 3];
    assign sif.swDown = ctrl_reg[i][qet_pkg::F_UD];
    assign sif.extDirEn = ctrl_reg[i][qet_pkg::F_UDE];
    assign sif.isAux = (i != 0);
    if (i == 0) begin : gRunCore
      assign sif.run = coreRun;
    end else begin : gRunAux
      assign sif.run = ctrl_reg[i][qet_pkg::F_REMOTE] ? coreRun : ctrl_reg[i][qet_pkg::F_RUN];
    end
    assign sif.cntLvl = pinSync_reg[PC];
    assign sif.cntRise = pinRise[PC];
    assign sif.cntFall = pinFall[PC];
    assign sif.dirLvl = pinSync_reg[PD];
    assign sif.dirRise = pinRise[PD];
    assign sif.dirFall = pinFall[PD];
    assign sif.presTick = qet_pkg::presTick(presCnt_reg, presShift);
    assign sif.otlRise = otlRise;
    assign sif.otlFall = otlFall;
    assign step[i] = sif.step;
    assign down[i] = sif.down;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters

  always_ff @(posedge mclk) begin
    for (int i = 0; i < qet_pkg::NUM_TMR; i++) begin
      if (rst) begin
        cnt_reg[i] <= qet_pkg::CNT_RST;
      end else if (wrCnt[i]) begin
        cnt_reg[i] <= regWrData;
      end else if (step[i]) begin
        cnt_reg[i] <= down[i] ? cnt_reg[i] - qet_pkg::CNT_ONE : cnt_reg[i] + qet_pkg::CNT_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core overflow and toggle latch

  assign coreOvf = step[0] & ~wrCnt[0] &
    (down[0] ? (cnt_reg[0] == qet_pkg::CNT_BOT) : (cnt_reg[0] == qet_pkg::CNT_TOP));

  assign otlRise = coreOvf & ~wrCtrl[0] & ~ctrl_reg[0][qet_pkg::F_OTL];
  assign otlFall = coreOvf & ~wrCtrl[0] & ctrl_reg[0][qet_pkg::F_OTL];

  assign encMode = (ctrl_reg[0][qet_pkg::F_MODE +: 3] == qet_pkg::MODE_ENC_ROT) ||
    (ctrl_reg[0][qet_pkg::F_MODE +: 3] == qet_pkg::MODE_ENC_EDGE);
  assign rotMode = ctrl_reg[0][qet_pkg::F_MODE +: 3] == qet_pkg::MODE_ENC_ROT;
  assign dirFlip = down[0] != ctrl_reg[0][qet_pkg::F_RDIR];

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_comb begin
    for (int i = 0; i < qet_pkg::NUM_TMR; i++) begin
      ctrl_next[i] = ctrl_reg[i];
      if (wrCtrl[i]) begin
        ctrl_next[i] = (i == 0) ?
          ((ctrl_reg[i] & ~qet_pkg::CORE_WMASK) | (regWrData & qet_pkg::CORE_WMASK)) :
          ((ctrl_reg[i] & ~qet_pkg::AUX_WMASK) | (regWrData & qet_pkg::AUX_WMASK));
      end
    end
    if (coreOvf && !wrCtrl[0]) begin
      ctrl_next[0][qet_pkg::F_OTL] = ~ctrl_reg[0][qet_pkg::F_OTL];
    end
    if (encMode && step[0]) begin
      ctrl_next[0][qet_pkg::F_RDIR] = down[0];
      ctrl_next[0][qet_pkg::F_EDGE] = 1'b1;
      if (dirFlip) begin
        ctrl_next[0][qet_pkg::F_CHDIR] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < qet_pkg::NUM_TMR; i++) begin
      if (rst) begin
        ctrl_reg[i] <= qet_pkg::CTRL_RST;
      end else begin
        ctrl_reg[i] <= ctrl_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request and output line

  always_ff @(posedge mclk) begin
    if (rst) begin
      coreIrq_reg <= 1'b0;
    end else begin
      coreIrq_reg <= encMode & step[0] & (~rotMode | dirFlip);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      timerOutputLine_reg <= 1'b0;
    end else begin
      timerOutputLine_reg <= ctrl_reg[0][qet_pkg::F_OTL] & ctrl_reg[0][qet_pkg::F_OE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  always_comb begin
    case (regAddr)
      qet_pkg::REG_CORE_CTRL: rdMux = ctrl_reg[0];
      qet_pkg::REG_CORE_CNT: rdMux = cnt_reg[0];
      qet_pkg::REG_AUXA_CTRL: rdMux = ctrl_reg[1];
      qet_pkg::REG_AUXA_CNT: rdMux = cnt_reg[1];
      qet_pkg::REG_AUXB_CTRL: rdMux = ctrl_reg[2];
      qet_pkg::REG_AUXB_CNT: rdMux = cnt_reg[2];
      qet_pkg::REG_PRESC: rdMux = {14'h0000, baseSel_reg};
      default: rdMux = 16'h0000;
    endcase
  end

  // data stand for exactly one cycle so a stale value is never mistaken for a fresh read
  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdData_reg <= 16'h0000;
    end else begin
      regRdData_reg <= regRd ? rdMux : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cbChk @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_enc_step_source: assert property (
    encMode && step[0] |-> pinRise[1:0] != 2'h0 || pinFall[1:0] != 2'h0
  ) else $error("encoder step without a phase edge");

  chk_enc_dir_table: assert property (
    encMode && coreRun && (ctrl_reg[0][qet_pkg::F_SEL +: 3] & qet_pkg::ENC_SEL_CNT) != 3'h0 &&
      !ctrl_reg[0][qet_pkg::F_SEL + 2] && pinRise[0] && pinSync_reg[1] && !wrCnt[0]
    |=> cnt_reg[0] == $past(cnt_reg[0]) - qet_pkg::CNT_ONE
  ) else $error("rising count phase with high direction did not count down");

  chk_rot_irq_change: assert property (
    rotMode && step[0] |=> coreIrq_reg == $past(dirFlip)
  ) else $error("rotation request does not match direction change");

  chk_edge_irq_every: assert property (
    ctrl_reg[0][qet_pkg::F_MODE +: 3] == qet_pkg::MODE_ENC_EDGE && step[0] |=> coreIrq_reg && ctrl_reg[0][qet_pkg::F_EDGE]
  ) else $error("edge mode count gave no request or flag");

  chk_rdir_follow: assert property (
    encMode && step[0] |=> ctrl_reg[0][qet_pkg::F_RDIR] == $past(down[0]) ##1 !$fell(ctrl_reg[0][qet_pkg::F_CHDIR]) ||
      $past(wrCtrl[0])
  ) else $error("direction status lost");

  chk_sw_write_wins: assert property (
    wrCnt[0] |=> cnt_reg[0] == $past(regWrData)
  ) else $error("counter write lost to hardware update");

  chk_otl_sw_quiet: assert property (
    wrCtrl[0] |-> !otlRise && !otlFall
  ) else $error("software latch write clocked an aux timer");

  chk_remote_run_off: assert property (
    ctrl_reg[1][qet_pkg::F_REMOTE] && !coreRun |-> !step[1]
  ) else $error("remote aux timer ran with core stopped");

  chk_aux_otl_both: assert property (
    ctrl_reg[1][qet_pkg::F_SEL +: 6] == {qet_pkg::MODE_COUNT, qet_pkg::CNT_SEL_OTL_ANY} && step[1] == 1'b0 |->
      !(otlRise || otlFall) ||
      !(ctrl_reg[1][qet_pkg::F_REMOTE] ? coreRun : ctrl_reg[1][qet_pkg::F_RUN])
  ) else $error("aux timer missed a latch toggle");

  chk_sync_latency: assert property (
    $rose(pinSync_reg[0]) |-> $past(pinMeta_reg[0])
  ) else $error("edge seen before second sync stage");

endmodule : qet_timer_top

// >>> src/qet_pkg.sv
// constants, field layout and helpers for the quadrature encoder timer block
// assumes one 16-bit register word per index on a simple strobe port
package qet_pkg;
  localparam int NUM_TMR = 3;
  localparam int NUM_PIN = 6;
  localparam int PIN_PER_TMR = 2;
  localparam int PIN_CNT_OFS = 0;
  localparam int PIN_DIR_OFS = 1;
  // register indices
  localparam logic [2:0] REG_CORE_CTRL = 3'h0;
  localparam logic [2:0] REG_CORE_CNT = 3'h1;
  localparam logic [2:0] REG_AUXA_CTRL = 3'h2;
  localparam logic [2:0] REG_AUXA_CNT = 3'h3;
  localparam logic [2:0] REG_AUXB_CTRL = 3'h4;
  localparam logic [2:0] REG_AUXB_CNT = 3'h5;
  localparam logic [2:0] REG_PRESC = 3'h6;
  // control fields, same position in every timer; bit 9 is F_OTL in the core and F_REMOTE in the aux timers
  localparam int F_SEL = 0;
  localparam int F_MODE = 3;
  localparam int F_RUN = 6;
  localparam int F_UD = 7;
  localparam int F_UDE = 8;
  localparam int F_OTL = 9;
  localparam int F_REMOTE = 9;
  localparam int F_OE = 10;
  localparam int F_RDIR = 11;
  localparam int F_CHDIR = 12;
  localparam int F_EDGE = 13;
  localparam logic [15:0] CORE_WMASK = 16'h37FF;
  localparam logic [15:0] AUX_WMASK = 16'h03FF;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_TOP = 16'hFFFF;
  localparam logic [15:0] CNT_BOT = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] PRES_RST = 16'h0000;
  localparam logic [1:0] BASE_RST = 2'h1;
  localparam logic [3:0] PRES_MIN_SHIFT = 4'h2;
  localparam logic [2:0] ENC_SEL_CNT = 3'h1;
  localparam logic [2:0] CNT_SEL_OTL_ANY = 3'h7;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
  typedef enum logic [2:0] {
    MODE_TIMER = 3'h0,
    MODE_COUNT = 3'h1,
    MODE_GATE_LO = 3'h2,
    MODE_GATE_HI = 3'h3,
    MODE_ENC_ROT = 3'h6,
    MODE_ENC_EDGE = 3'h7
  } qet_mode_t;

  function automatic logic presTick(input logic [15:0] cnt, input logic [3:0] sh);
    logic [15:0] m;
    m = ~(CNT_TOP << sh);
    return (cnt & m) == m;
  endfunction : presTick

  function automatic logic [2:0] ctrlAddr(input int i);
    return (i == 0) ? REG_CORE_CTRL : ((i == 1) ? REG_AUXA_CTRL : REG_AUXB_CTRL);
  endfunction : ctrlAddr

  function automatic logic [2:0] cntAddr(input int i);
    return (i == 0) ? REG_CORE_CNT : ((i == 1) ? REG_AUXA_CNT : REG_AUXB_CNT);
  endfunction : cntAddr
endpackage : qet_pkg

// >>> src/qet_step_if.sv
// per-timer signals between the register side and the step decoder
// assumes all members are driven in the mclk domain
`timescale 1ns/100ps
interface qet_step_if;
  logic [2:0] mode;
  logic [2:0] sel;
  logic run;
  logic swDown;
  logic extDirEn;
  logic isAux;
  logic cntLvl;
  logic cntRise;
  logic cntFall;
  logic dirLvl;
  logic dirRise;
  logic dirFall;
  logic presTick;
  logic otlRise;
  logic otlFall;
  logic step;
  logic down;
  modport decoder(
    input mode, sel, run, swDown, extDirEn, isAux, cntLvl, cntRise, cntFall,
    input dirLvl, dirRise, dirFall, presTick, otlRise, otlFall,
    output step, down
  );
  modport owner(
    output mode, sel, run, swDown, extDirEn, isAux, cntLvl, cntRise, cntFall,
    output dirLvl, dirRise, dirFall, presTick, otlRise, otlFall,
    input step, down
  );
endinterface : qet_step_if

// >>> src/qet_step_decode.sv
// decides whether one timer steps this cycle and in which direction
// assumes edges come from synchronised samples, one cycle wide
`timescale 1ns/100ps
module qet_step_decode (
  // decoder side of one timer
  qet_step_if.decoder sif
);
  logic ownHit;
  logic otlHit;
  logic selHit;
  logic encCnt;
  logic encDir;
  logic encDown;
  logic dirDown;

  always_comb begin
    case (sif.sel[1:0])
      qet_pkg::EDGE_RISE: begin
        ownHit = sif.cntRise;
        otlHit = sif.otlRise;
      end
      qet_pkg::EDGE_FALL: begin
        ownHit = sif.cntFall;
        otlHit = sif.otlFall;
      end
      qet_pkg::EDGE_ANY: begin
        ownHit = sif.cntRise | sif.cntFall;
        otlHit = sif.otlRise | sif.otlFall;
      end
      default: begin
        ownHit = 1'b0;
        otlHit = 1'b0;
      end
    endcase
  end

  always_comb begin
    selHit = sif.sel[2] ? (sif.isAux & otlHit) : ownHit;
    encCnt = ~sif.sel[2] & sif.sel[0] & (sif.cntRise | sif.cntFall);
    encDir = ~sif.sel[2] & sif.sel[1] & (sif.dirRise | sif.dirFall);
    if (encCnt) begin
      encDown = sif.cntRise ? sif.dirLvl : ~sif.dirLvl;
    end else begin
      encDown = sif.dirRise ? ~sif.cntLvl : sif.cntLvl;
    end
    dirDown = sif.extDirEn ? (sif.dirLvl ^ sif.swDown) : sif.swDown;
    sif.step = 1'b0;
    sif.down = dirDown;
    case (sif.mode)
      qet_pkg::MODE_TIMER: begin
        sif.step = sif.run & sif.presTick;
      end
      qet_pkg::MODE_COUNT: begin
        sif.step = sif.run & selHit;
      end
      qet_pkg::MODE_GATE_LO, qet_pkg::MODE_GATE_HI: begin
        sif.step = sif.run & sif.presTick & (sif.cntLvl == sif.mode[0]);
      end
      qet_pkg::MODE_ENC_ROT, qet_pkg::MODE_ENC_EDGE: begin
        sif.step = sif.run & (encCnt | encDir);
        sif.down = encDown;
      end
      default: begin
        sif.step = 1'b0;
      end
    endcase
  end
endmodule : qet_step_decode

// >>> sim/qet_encoder_model.sv
// behavioural incremental encoder driving the core phase pins
// assumes the bench calls its tasks from one process only
`timescale 1ns/100ps
module qet_encoder_model (
  // clock
  input wire logic mclk,
  // phase outputs
  output logic phaseA,
  output logic phaseB
);
  initial begin
    phaseA = 1'b0;
    phaseB = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // hold each level
  // seven cycles per level keeps both phases well below clock/8
  task automatic setPh(input logic a, input logic b);
    @(posedge mclk);
    phaseA <= a;
    phaseB <= b;
    repeat (6) @(posedge mclk);
  endtask : setPh

  // one quadrature step; forward walks 00, 10, 11, 01
  task automatic stepEnc(input logic fwd);
    if (fwd) begin
      setPh(~phaseB, phaseA);
    end else begin
      setPh(phaseB, ~phaseA);
    end
  endtask : stepEnc
endmodule : qet_encoder_model

// >>> sim/quadrature_encoder_timer_block_tb_top.sv
// self-checking bench for the encoder timer block
// assumes the encoder model owns the core phase pins
`timescale 1ns/100ps
module quadrature_encoder_timer_block_tb_top;
  logic mclk = 1'b0;
  logic rst;
  logic [2:0] regAddr;
  logic [15:0] regWrData;
  logic regWr;
  logic regRd;
  logic [15:0] regRdData;
  logic coreCountIn;
  logic coreDirIn;
  logic auxACountIn;
  logic auxADirIn;
  logic auxBCountIn;
  logic auxBDirIn;
  logic timerOutputLine;
  logic coreIrq;
  int failures = 0;
  int check_count = 0;
  int irqCount = 0;

  always #2 mclk = ~mclk;

  qet_encoder_model encModel (.mclk(mclk), .phaseA(coreCountIn), .phaseB(coreDirIn));

  qet_timer_top uut (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .coreCountIn(coreCountIn), .coreDirIn(coreDirIn), .auxACountIn(auxACountIn),
    .auxADirIn(auxADirIn), .auxBCountIn(auxBCountIn), .auxBDirIn(auxBDirIn), .timerOutputLine(timerOutputLine),
    .coreIrq(coreIrq)
  );

  always @(posedge mclk) begin
    if (coreIrq === 1'b1) irqCount <= irqCount + 1;
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic regWrite(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : regWrite

  task automatic chkReg(input string what, input logic [2:0] a, input logic [15:0] exp);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk(what, exp, regRdData);
  endtask : chkReg

  function automatic logic [15:0] mkCtrl(input logic [2:0] sel, input logic [2:0] mode, input logic run,
                                         input logic ude, input logic b9);
    logic [15:0] v;
    v = 16'h0000;
    v[qet_pkg::F_SEL +: 3] = sel;
    v[qet_pkg::F_MODE +: 3] = mode;
    v[qet_pkg::F_RUN] = run;
    v[qet_pkg::F_UDE] = ude;
    v[qet_pkg::F_REMOTE] = b9;
    return v;
  endfunction : mkCtrl

  // full pulses, high held six cycles and low seven cycles between pulses
  task automatic auxPulse(input bit useB, input int n);
    repeat (n) begin
      @(posedge mclk);
      if (useB) auxBCountIn <= 1'b1; else auxACountIn <= 1'b1;
      repeat (6) @(posedge mclk);
      if (useB) auxBCountIn <= 1'b0; else auxACountIn <= 1'b0;
      repeat (6) @(posedge mclk);
    end
  endtask : auxPulse

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      chkReg("reset value", i[2:0], (i == 6) ? 16'h0001 : 16'h0000);
    end
    regWrite(3'h7, 16'hFFFF);
    chkReg("unmapped index", 3'h7, 16'h0000);
    regWrite(qet_pkg::REG_AUXA_CTRL, 16'hFC00);
    chkReg("aux upper bits", qet_pkg::REG_AUXA_CTRL, 16'h0000);
  endtask : t_reset

  task automatic t_enc_edge();
    int base;
    regWrite(qet_pkg::REG_CORE_CNT, 16'h0100);
    regWrite(qet_pkg::REG_CORE_CTRL, mkCtrl(3'h3, 3'h7, 1'b1, 1'b1, 1'b0));
    base = irqCount;
    repeat (4) encModel.stepEnc(1'b1);
    chkReg("edge count", qet_pkg::REG_CORE_CNT, 16'h0104);
    @(posedge mclk);
    #1;
    chk("read data released", 16'h0000, regRdData);
    chk("edge requests", 16'h0004, 16'(irqCount - base));
    chkReg("edge ctrl flags", qet_pkg::REG_CORE_CTRL, 16'h217B);
    repeat (3) begin
      encModel.stepEnc(1'b1);
      encModel.stepEnc(1'b0);
    end
    chkReg("jitter count", qet_pkg::REG_CORE_CNT, 16'h0104);
  endtask : t_enc_edge

  task automatic t_enc_rot();
    int base;
    regWrite(qet_pkg::REG_CORE_CNT, 16'h0200);
    regWrite(qet_pkg::REG_CORE_CTRL, mkCtrl(3'h3, 3'h6, 1'b1, 1'b1, 1'b0));
    encModel.stepEnc(1'b1);
    base = irqCount;
    encModel.stepEnc(1'b1);
    chk("same direction", 16'h0000, 16'(irqCount - base));
    encModel.stepEnc(1'b0);
    chk("reversal request", 16'h0001, 16'(irqCount - base));
    chkReg("reversal count", qet_pkg::REG_CORE_CNT, 16'h0201);
    chkReg("reversal flags", qet_pkg::REG_CORE_CTRL, 16'h3973);
  endtask : t_enc_rot

  task automatic t_enc_sel();
    logic [15:0] exp [4] = '{16'h0300, 16'h0302, 16'h0302, 16'h0304};
    for (int s = 0; s < 4; s++) begin
      regWrite(qet_pkg::REG_CORE_CNT, 16'h0300);
      regWrite(qet_pkg::REG_CORE_CTRL, mkCtrl(s[2:0], 3'h7, 1'b1, 1'b1, 1'b0));
      repeat (4) encModel.stepEnc(1'b1);
      chkReg("select count", qet_pkg::REG_CORE_CNT, exp[s]);
    end
    // backward walk gives all four down cases, one per edge kind
    repeat (4) encModel.stepEnc(1'b0);
    chkReg("reverse count", qet_pkg::REG_CORE_CNT, 16'h0300);
  endtask : t_enc_sel

  task automatic t_aux_cnt();
    logic [15:0] exp [5] = '{16'h0000, 16'h0003, 16'h0003, 16'h0006, 16'h0000};
    for (int s = 0; s < 5; s++) begin
      regWrite(qet_pkg::REG_AUXA_CNT, 16'h0000);
      regWrite(qet_pkg::REG_AUXA_CTRL, mkCtrl(s[2:0], 3'h1, 1'b1, 1'b0, 1'b0));
      auxPulse(1'b0, 3);
      chkReg("aux input count", qet_pkg::REG_AUXA_CNT, exp[s]);
    end
    @(posedge mclk);
    auxADirIn <= 1'b1;
    regWrite(qet_pkg::REG_AUXA_CNT, 16'h0010);
    regWrite(qet_pkg::REG_AUXA_CTRL, mkCtrl(3'h3, 3'h1, 1'b1, 1'b1, 1'b0));
    auxPulse(1'b0, 1);
    chkReg("aux pin direction", qet_pkg::REG_AUXA_CNT, 16'h000E);
  endtask : t_aux_cnt

  task automatic t_remote();
    regWrite(qet_pkg::REG_CORE_CTRL, mkCtrl(3'h0, 3'h1, 1'b0, 1'b0, 1'b0));
    regWrite(qet_pkg::REG_AUXB_CNT, 16'h0000);
    regWrite(qet_pkg::REG_AUXB_CTRL, mkCtrl(3'h3, 3'h1, 1'b0, 1'b0, 1'b1));
    auxPulse(1'b1, 2);
    chkReg("remote stopped", qet_pkg::REG_AUXB_CNT, 16'h0000);
    regWrite(qet_pkg::REG_CORE_CTRL, mkCtrl(3'h0, 3'h1, 1'b1, 1'b0, 1'b0));
    auxPulse(1'b1, 2);
    chkReg("remote running", qet_pkg::REG_AUXB_CNT, 16'h0004);
    @(posedge mclk);
    auxBDirIn <= 1'b1;
    regWrite(qet_pkg::REG_AUXB_CTRL, mkCtrl(3'h3, 3'h1, 1'b0, 1'b1, 1'b1));
    auxPulse(1'b1, 1);
    chkReg("remote down", qet_pkg::REG_AUXB_CNT, 16'h0002);
  endtask : t_remote

  task automatic t_chain();
    logic [15:0] exp [3] = '{16'h0001, 16'h0001, 16'h0002};
    encModel.setPh(1'b0, 1'b0);
    regWrite(qet_pkg::REG_CORE_CTRL, mkCtrl(3'h1, 3'h1, 1'b1, 1'b0, 1'b0));
    for (int s = 0; s < 3; s++) begin
      regWrite(qet_pkg::REG_AUXA_CNT, 16'h0000);
      regWrite(qet_pkg::REG_AUXA_CTRL, mkCtrl(3'(s + 5), 3'h1, 1'b1, 1'b0, 1'b0));
      repeat (2) begin
        regWrite(qet_pkg::REG_CORE_CNT, 16'hFFFF);
        encModel.setPh(1'b1, 1'b0);
        encModel.setPh(1'b0, 1'b0);
      end
      chkReg("latch edge count", qet_pkg::REG_AUXA_CNT, exp[s]);
    end
    // latch now low after an even number of wraps
    regWrite(qet_pkg::REG_CORE_CTRL, mkCtrl(3'h1, 3'h1, 1'b1, 1'b0, 1'b1));
    chkReg("software latch", qet_pkg::REG_AUXA_CNT, 16'h0002);
    chk("output line disabled", 16'h0000, {15'h0000, timerOutputLine});
    regWrite(qet_pkg::REG_CORE_CTRL, mkCtrl(3'h1, 3'h1, 1'b1, 1'b0, 1'b1) | 16'h0400);
    repeat (2) @(posedge mclk);
    #1;
    chk("output line", 16'h0001, {15'h0000, timerOutputLine});
  endtask : t_chain

  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // the sequence needs under a thousand cycles; allow ample margin
  initial begin
    #200000;
    failures++;
    give_verdict();
  end

  initial begin
    rst <= 1'b1;
    regAddr <= 3'h0;
    regWrData <= 16'h0000;
    regWr <= 1'b0;
    regRd <= 1'b0;
    auxACountIn <= 1'b0;
    auxADirIn <= 1'b0;
    auxBCountIn <= 1'b0;
    auxBDirIn <= 1'b0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_enc_edge();
    t_enc_rot();
    t_enc_sel();
    t_aux_cnt();
    t_remote();
    t_chain();
    give_verdict();
  end
endmodule : quadrature_encoder_timer_block_tb_top
